// ---- design/decoder_pkg.sv ----
// constants for the instruction decoder and its register window
package decoder_pkg;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] ctrl_offset      = 8'h00;
    localparam logic [7:0] word_offset      = 8'h04;
    localparam logic [7:0] bank_offset      = 8'h08;
    localparam logic [7:0] op_offset        = 8'h0c;
    localparam logic [7:0] addr_offset      = 8'h10;
    localparam logic [7:0] operand_offset   = 8'h14;
    localparam logic [7:0] status_offset    = 8'h18;
    localparam logic [7:0] ident_offset     = 8'h1c;

    // ************************************************************
    // field positions, reset values, counts
    // ************************************************************
    localparam int          osc_per_cycle   = 4;
    localparam logic [1:0]  phase_last      = 2'h3;
    localparam logic [3:0]  bank_reset      = 4'h0;
    localparam logic [15:0] word_reset      = 16'h0000;
    localparam logic [3:0]  timer_zero_count_bank       = 4'hf;
    localparam logic [7:0]  timer_zero_count_low_addr   = 8'hd6;
    localparam logic [31:0] ident_value     = 32'h00c0_ffee; // arbitrary

    // flag mask bits: c dc z ov n
    localparam logic [4:0]  fl_none         = 5'h00;
    localparam logic [4:0]  fl_all          = 5'h1f;
    localparam logic [4:0]  fl_zn           = 5'h05;
    localparam logic [4:0]  fl_czn          = 5'h15;
    localparam logic [4:0]  fl_z            = 5'h04;
    localparam logic [4:0]  fl_c            = 5'h10;

    // ************************************************************
    // operation classes
    // ************************************************************
    typedef enum logic [3:0] {
        cls_nop     = 4'h0,
        cls_byte    = 4'h1,
        cls_bit     = 4'h2,
        cls_literal = 4'h3,
        cls_branch  = 4'h4,
        cls_jump    = 4'h5,
        cls_call    = 4'h6,
        cls_return  = 4'h7,
        cls_move    = 4'h8,
        cls_stack   = 4'h9,
        cls_system  = 4'ha,
        cls_skip    = 4'hb
    } op_class_e;

    typedef enum logic [1:0] {
        st_fresh    = 2'b00,
        st_second   = 2'b01
    } fetch_state_e;

endpackage

// ---- design/instruction_decoder.sv ----
// instruction decoder with apb register window
// ****************************************************************
// ****************************************************************
module instruction_decoder
    import decoder_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        prescaler_on_timer,
    output logic             cycle_strobe,
    output logic             prescaler_clear,
    output logic             software_reset
);
    import decoder_pkg::*;

    // ************************************************************
    // apb decode
    // ************************************************************
    wire        access     = psel && penable;
    wire        wr         = access && pwrite;
    wire        hit_ctrl   = paddr == ctrl_offset;
    wire        hit_word   = paddr == word_offset;
    wire        hit_bank   = paddr == bank_offset;
    wire        mapped     = hit_ctrl || hit_word || hit_bank
                          || paddr == op_offset || paddr == addr_offset
                          || paddr == operand_offset
                          || paddr == status_offset
                          || paddr == ident_offset;

    // ************************************************************
    // state
    // ************************************************************
    logic [1:0]   phase_reg;
    logic         run_reg;
    logic         word_pending_reg;
    logic [15:0]  word_reg;
    logic [3:0]   bank_reg;
    fetch_state_e fetch_reg;
    logic [15:0]  first_reg;
    logic [3:0]   class_reg;
    logic [11:0]  addr_reg;
    logic [19:0]  operand_reg;
    logic [4:0]   flags_reg;
    logic [1:0]   cycles_reg;
    logic [7:0]   ctl_reg;
    logic         pre_clr_reg;
    logic         srst_reg;

    assign cycle_strobe = run_reg && phase_reg == phase_last;

    // ************************************************************
    // field extraction
    // ************************************************************
    wire [3:0]  hi   = word_reg[15:12];
    wire [3:0]  nib2 = word_reg[11:8];
    wire [7:0]  f8   = word_reg[7:0];
    wire        abit = word_reg[8];
    wire        dbit = word_reg[9];
    wire [2:0]  bnum = word_reg[11:9];
    wire        fast = word_reg[0];

    function automatic logic [11:0] bank_addr(input logic a,
                                              input logic [3:0] b,
                                              input logic [7:0] f);
        bank_addr = a ? {b, f} : {(f[7] ? 4'hf : 4'h0), f};
    endfunction

    // opcode decode: class, flags, fields, writes file
    logic [3:0]  cls_n;
    logic [4:0]  fl_n;
    logic [11:0] addr_n;
    logic [19:0] opnd_n;
    logic [1:0]  cyc_n;
    logic [7:0]  ctl_n;
    logic        two_word;

    always_comb begin
        cls_n    = cls_nop;
        fl_n     = fl_none;
        addr_n   = bank_addr(abit, bank_reg, f8);
        opnd_n   = '0;
        cyc_n    = 2'd1;
        ctl_n    = '0;
        two_word = 1'b0;
        unique case (hi)
            4'h0: begin
                if (nib2 == 4'h0) begin
                    cls_n = cls_system;
                    ctl_n = f8;
                    if (f8 == 8'h05 || f8 == 8'h06) begin
                        cls_n = cls_stack;
                    end else if (f8[7:1] == 7'h08 || f8[7:1] == 7'h09) begin
                        cls_n = cls_return;
                        cyc_n = 2'd2;
                        opnd_n = {19'h0, fast};
                    end else if (f8 == 8'h04 || f8 == 8'h03) begin
                        fl_n = fl_none;
                    end
                end else if (nib2[3:1] == 3'h1) begin
                    cls_n = cls_byte;
                    ctl_n = 8'h12;
                end else if (nib2[3:2] == 2'h1) begin
                    cls_n = cls_byte;
                    fl_n  = fl_all;
                end else begin
                    cls_n  = nib2 == 4'hc ? cls_return : cls_literal;
                    opnd_n = {12'h0, f8};
                    cyc_n  = nib2 == 4'hc ? 2'd2 : 2'd1;
                    if (nib2 == 4'hf || nib2 == 4'h8) begin
                        fl_n = fl_all;
                    end else if (nib2 >= 4'h9 && nib2 <= 4'hb) begin
                        fl_n = fl_zn;
                    end
                end
            end
            4'h1: begin
                cls_n = cls_byte;
                fl_n  = fl_zn;
            end
            4'h2: begin
                cls_n = nib2[3:2] == 2'h3 ? cls_skip : cls_byte;
                fl_n  = nib2[3:2] == 2'h3 ? fl_none : fl_all;
            end
            4'h3: begin
                cls_n = nib2[3:2] == 2'h3 ? cls_skip : cls_byte;
                unique case (nib2[3:2])
                    2'h0, 2'h1: fl_n = fl_czn;
                    2'h2:       fl_n = fl_none;
                    default:    fl_n = fl_none;
                endcase
            end
            4'h4: begin
                cls_n = nib2[3] ? cls_skip : cls_byte;
                fl_n  = nib2[3] ? fl_none : fl_zn;
            end
            4'h5: begin
                cls_n = cls_byte;
                fl_n  = nib2[3:2] == 2'h0 ? fl_zn : fl_all;
            end
            4'h6: begin
                cls_n = nib2[3] ? cls_byte : cls_skip;
                if (nib2[3:1] == 3'h5) begin
                    fl_n = fl_z;
                end else if (nib2[3:1] == 3'h6) begin
                    fl_n = fl_all;
                end
            end
            4'h7, 4'h8, 4'h9: begin
                cls_n  = cls_bit;
                opnd_n = {17'h0, bnum};
            end
            4'ha, 4'hb: begin
                cls_n  = cls_skip;
                opnd_n = {17'h0, bnum};
            end
            4'hc: begin
                cls_n    = cls_move;
                addr_n   = word_reg[11:0];
                cyc_n    = 2'd2;
                two_word = 1'b1;
            end
            4'hd: begin
                cls_n  = word_reg[11] ? cls_call : cls_jump;
                opnd_n = {{9{word_reg[10]}}, word_reg[10:0]};
                cyc_n  = 2'd2;
            end
            4'he: begin
                if (!word_reg[11]) begin
                    cls_n  = cls_branch;
                    opnd_n = {{12{f8[7]}}, f8};
                    ctl_n  = {5'h0, word_reg[10:8]};
                end else if (nib2 == 4'he) begin
                    cls_n    = cls_literal;
                    addr_n   = {10'h0, f8[5:4]};
                    opnd_n   = {16'h0, f8[3:0]};
                    cyc_n    = 2'd2;
                    two_word = 1'b1;
                end else begin
                    cls_n    = nib2 == 4'hf ? cls_jump : cls_call;
                    opnd_n   = {12'h0, f8};
                    ctl_n    = {7'h0, word_reg[8]};
                    cyc_n    = 2'd2;
                    two_word = nib2 == 4'hc || nib2 == 4'hd
                            || nib2 == 4'hf;
                end
            end
            4'hf: begin
                cls_n = cls_nop;
            end
        endcase
    end

    wire file_write = (cls_n == cls_byte && dbit && hi != 4'h6
                       && !(hi == 4'h0 && nib2[3:1] == 3'h1))
                   || (cls_n == cls_skip && dbit && hi >= 4'h2
                       && hi <= 4'h4)
                   || (hi == 4'h6 && nib2[3:1] >= 3'h4)
                   || cls_n == cls_bit;
    wire hits_timer_zero_count  = addr_n == {timer_zero_count_bank, timer_zero_count_low_addr};

    // ************************************************************
    // apb writes and cycle pacing
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg   <= 1'b0;
            bank_reg  <= bank_reset;
            phase_reg <= 2'h0;
        end else begin
            if (wr && hit_ctrl) begin
                run_reg <= pwdata[0];
            end
            if (wr && hit_bank) begin
                bank_reg <= pwdata[3:0];
            end
            if (run_reg) begin
                phase_reg <= phase_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_reg         <= word_reset;
            word_pending_reg <= 1'b0;
        end else if (wr && hit_word) begin
            word_reg         <= pwdata[15:0];
            word_pending_reg <= 1'b1;
        end else if (cycle_strobe) begin
            word_pending_reg <= 1'b0;
        end
    end

    // ************************************************************
    // decode commit, once per instruction cycle
    // ************************************************************
    wire commit = cycle_strobe && word_pending_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_reg   <= st_fresh;
            first_reg   <= '0;
            class_reg   <= cls_nop;
            addr_reg    <= '0;
            operand_reg <= '0;
            flags_reg   <= fl_none;
            cycles_reg  <= 2'd0;
            ctl_reg     <= '0;
            pre_clr_reg <= 1'b0;
            srst_reg    <= 1'b0;
        end else begin
            pre_clr_reg <= 1'b0;
            srst_reg    <= 1'b0;
            if (commit) begin
                unique case (fetch_reg)
                    st_fresh: begin
                        class_reg   <= cls_n;
                        addr_reg    <= addr_n;
                        operand_reg <= opnd_n;
                        flags_reg   <= fl_n;
                        cycles_reg  <= cyc_n;
                        ctl_reg     <= ctl_n;
                        first_reg   <= word_reg;
                        if (two_word) begin
                            fetch_reg <= st_second;
                        end
                        pre_clr_reg <= file_write && hits_timer_zero_count
                                    && prescaler_on_timer;
                        srst_reg    <= hi == 4'h0 && nib2 == 4'h0
                                    && f8 == 8'hff;
                    end
                    st_second: begin
                        fetch_reg <= st_fresh;
                        if (first_reg[15:12] == 4'hc) begin
                            operand_reg <= {8'h0, word_reg[11:0]};
                            pre_clr_reg <= word_reg[11:0]
                                        == {timer_zero_count_bank, timer_zero_count_low_addr}
                                        && prescaler_on_timer;
                        end else if (first_reg[11:8] == 4'he) begin
                            operand_reg <= {8'h0, operand_reg[3:0],
                                            word_reg[7:0]};
                        end else begin
                            operand_reg <= {word_reg[11:0],
                                            operand_reg[7:0]};
                        end
                    end
                    default: fetch_reg <= st_fresh;
                endcase
            end
        end
    end

    assign prescaler_clear = pre_clr_reg;
    assign software_reset  = srst_reg;

    // ************************************************************
    // apb read
    // ************************************************************
    wire [31:0] status_word = {16'h0, ctl_reg, 1'b0, flags_reg,
                               fetch_reg == st_second, run_reg};

    always_comb begin
        unique case (paddr)
            ctrl_offset:    prdata = {31'h0, run_reg};
            word_offset:    prdata = {16'h0, word_reg};
            bank_offset:    prdata = {28'h0, bank_reg};
            op_offset:      prdata = {26'h0, cycles_reg, class_reg};
            addr_offset:    prdata = {20'h0, addr_reg};
            operand_offset: prdata = {12'h0, operand_reg};
            status_offset:  prdata = status_word;
            ident_offset:   prdata = ident_value;
            default:        prdata = 32'h0;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

endmodule

// ---- testbench/decoder_checker_assertions.sv ----
// port assertions for the instruction decoder
// ************
// port checker
// ************
module decoder_checker
    import decoder_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        prescaler_on_timer,
    input wire logic        cycle_strobe,
    input wire logic        prescaler_clear,
    input wire logic        software_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_quiet;
        !cycle_strobe[*3];
    endsequence
    sequence s_decoded;
        cycle_strobe ##1 !software_reset;
    endsequence
    property p_gap;
        cycle_strobe |=> s_quiet;
    endproperty
    a_gap: assert property (p_gap) else $error("strobe early");
    property p_period;
        s_decoded |-> ##3 cycle_strobe;
    endproperty
    a_period: assert property (p_period) else $error("strobe late");
    property p_clear_cause;
        prescaler_clear |-> $past(cycle_strobe) && $past(prescaler_on_timer);
    endproperty
    a_clear_cause: assert property (p_clear_cause)
        else $error("bad clear");
    property p_sreset_cause;
        software_reset |-> $past(cycle_strobe);
    endproperty
    a_sreset_cause: assert property (p_sreset_cause)
        else $error("bad reset");
    property p_pulses;
        prescaler_clear || software_reset
            |=> !prescaler_clear && !software_reset;
    endproperty
    a_pulses: assert property (p_pulses)
        else $error("pulse too long");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_unmapped;
        psel && penable && paddr > 8'h1c
            |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access");
    property p_ident;
        psel && !pwrite && paddr == ident_offset |-> prdata == ident_value;
    endproperty
    a_ident: assert property (p_ident) else $error("ident mismatch");
endmodule

bind instruction_decoder decoder_checker chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cycle_strobe(cycle_strobe),
    .prescaler_on_timer(prescaler_on_timer),
    .prescaler_clear(prescaler_clear), .software_reset(software_reset));

// ---- testbench/timer_side_model.sv ----
// far-side model: prescaler assignment level and pulse counters
module timer_side_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic assign_req,
    input  wire logic prescaler_clear,
    input  wire logic software_reset,
    output logic      prescaler_on_timer,
    output logic [31:0] clear_count,
    output logic [31:0] reset_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************
    // level and counts
    // ************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescaler_on_timer <= 1'b0;
            clear_count        <= '0;
            reset_count        <= '0;
        end else begin
            prescaler_on_timer <= assign_req;
            clear_count        <= clear_count + 32'(prescaler_clear);
            reset_count        <= reset_count + 32'(software_reset);
        end
    end
endmodule

// ---- testbench/mcu_instruction_decoder_bench.sv ----
// self-checking bench for the instruction decoder
module mcu_instruction_decoder_bench
    import decoder_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ************
    // stimulus and checking
    // ************
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        assign_req = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, prescaler_on_timer;
    logic        cycle_strobe, prescaler_clear, software_reset;
    logic [64:0] exp_q [$];
    logic [64:0] e;
    logic [26:0] ent;
    logic [7:0]  f;
    logic [3:0]  b;
    logic [3:0]  bit_ops [5] = '{4'h9, 4'h8, 4'hb, 4'ha, 4'h7};
    int          bad_count = 0;
    int          n_checks = 0;
    logic [31:0] clear_count, reset_count;
    logic [20:0] tbl_a [17] = '{
        {16'h2634, fl_all}, {16'h2012, fl_all}, {16'h2812, fl_all},
        {16'h0412, fl_all}, {16'h1012, fl_zn}, {16'h1412, fl_zn},
        {16'h1812, fl_zn}, {16'h1c12, fl_zn}, {16'h5c12, fl_all},
        {16'h5812, fl_all}, {16'h5412, fl_all}, {16'h3412, fl_czn},
        {16'h3012, fl_czn}, {16'h4412, fl_zn}, {16'h4012, fl_zn},
        {16'h3812, fl_none}, {16'h0212, fl_none}};
    logic [21:0] tbl_b [17] = '{
        {16'h6212, cls_skip, 2'h1}, {16'h6412, cls_skip, 2'h1},
        {16'h6012, cls_skip, 2'h1}, {16'h6612, cls_skip, 2'h1},
        {16'hd005, cls_jump, 2'h2}, {16'hd805, cls_call, 2'h2},
        {16'h0005, cls_stack, 2'h1}, {16'h0006, cls_stack, 2'h1},
        {16'h0010, cls_return, 2'h2}, {16'h0011, cls_return, 2'h2},
        {16'h0012, cls_return, 2'h2}, {16'h0013, cls_return, 2'h2},
        {16'h0c55, cls_return, 2'h2}, {16'hf123, cls_nop, 2'h1},
        {16'h0e7f, cls_literal, 2'h1}, {16'h0004, cls_system, 2'h1},
        {16'h0003, cls_system, 2'h1}};

    always #2.5 pclk = ~pclk;

    instruction_decoder uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cycle_strobe(cycle_strobe),
        .prescaler_on_timer(prescaler_on_timer),
        .prescaler_clear(prescaler_clear), .software_reset(software_reset));
    timer_side_model partner (
        .pclk(pclk), .presetn(presetn), .assign_req(assign_req),
        .prescaler_clear(prescaler_clear), .software_reset(software_reset),
        .prescaler_on_timer(prescaler_on_timer),
        .clear_count(clear_count), .reset_count(reset_count));

    task automatic compare_word(input logic [31:0] g, x, m,
                                input logic ge, xe);
        n_checks++;
        if (((g & m) !== x) || (ge !== xe)) begin
            bad_count++;
            $display("[FAIL] %0t read %h/%b want %h/%b", $time, g & m, ge,
                     x, xe);
        end
    endtask

    task automatic compare_count(input logic [31:0] g, x);
        n_checks++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] %0t count %0d want %0d", $time, g, x);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, m,
                      input logic err = 1'b0);
        exp_q.push_back({err, m, x & m});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic exec(input logic [15:0] w);
        apb(1'b1, word_offset, {16'h0, w});
        do @(posedge pclk); while (cycle_strobe !== 1'b1);
        repeat (2) @(posedge pclk);
    endtask

    task automatic dec(input logic [26:0] v);
        exec(v[26:11]);
        rd(op_offset, {26'h0, v[6:5], v[10:7]}, 32'h3f);
        rd(status_offset, {25'h0, v[4:0], 2'h1}, 32'h7f);
    endtask

    task automatic two(input logic [15:0] w1, w2, input logic [3:0] c,
                       input logic [19:0] v);
        exec(w1);
        rd(status_offset, 32'h3, 32'h3);
        exec(w2);
        rd(operand_offset, {12'h0, v}, 32'hfffff);
        rd(op_offset, {26'h0, 2'h2, c}, 32'h3f);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            compare_word(prdata, e[31:0], e[63:32], pslverr, e[64]);
        end
    end

    initial begin
        #100000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done;
    end

    initial begin
        void'($urandom(30199));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ctrl_offset, 32'h0, 32'h1);
        rd(bank_offset, {28'h0, bank_reset}, 32'hf);
        rd(status_offset, 32'h0, 32'h3);
        rd(ident_offset, ident_value, 32'hffffffff);
        rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b1, ctrl_offset, 32'h1);
        $display("reset values done");
        foreach (tbl_a[i]) begin
            ent = {tbl_a[i][20:5], cls_byte, 2'h1, tbl_a[i][4:0]};
            dec(ent);
        end
        foreach (tbl_b[i]) begin
            ent = {tbl_b[i], fl_none};
            dec(ent);
        end
        $display("opcode tables done");
        for (int i = 0; i < 5; i++) begin
            exec({bit_ops[i], 3'(i + 2), 1'b0, 8'h34});
            rd(operand_offset, 32'(i + 2), 32'h7);
            rd(status_offset, 32'h1, 32'h7f);
        end
        for (int c = 0; c < 8; c++) begin
            exec({5'h1c, 3'(c), 8'hf0});
            rd(op_offset, {26'h0, 2'h1, cls_branch}, 32'h3f);
            rd(operand_offset, 32'hffff0, 32'hfffff);
        end
        exec(16'hd400);
        rd(operand_offset, 32'hffc00, 32'hfffff);
        f = 8'($urandom);
        exec({8'h0e, f});
        rd(operand_offset, {24'h0, f}, 32'hff);
        exec(16'h0011);
        rd(operand_offset, 32'h1, 32'h1);
        exec(16'h0010);
        rd(operand_offset, 32'h0, 32'h1);
        $display("operand fields done");
        for (int i = 0; i < 2; i++) begin
            b = 4'($urandom);
            f = {i[0], 7'($urandom)};
            if (f == timer_zero_count_low_addr) begin
                f[0] = ~f[0];
            end
            apb(1'b1, bank_offset, {28'h0, b});
            rd(bank_offset, {28'h0, b}, 32'hf);
            exec({8'h27, f});
            rd(addr_offset, {20'h0, b, f}, 32'hfff);
            exec({8'h26, f});
            rd(addr_offset, {20'h0, {4{f[7]}}, f}, 32'hfff);
        end
        two(16'hc123, 16'hf456, cls_move, 20'h00456);
        two(16'hef12, 16'hf345, cls_jump, 20'h34512);
        two(16'hed34, 16'hf001, cls_call, 20'h00134);
        rd(status_offset, 32'h100, 32'h100);
        two(16'hee25, 16'hf0ab, cls_literal, 20'h005ab);
        rd(addr_offset, 32'h2, 32'hfff);
        exec(16'hc123);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(status_offset, 32'h0, 32'h3);
        apb(1'b1, ctrl_offset, 32'h1);
        exec(16'hf000);
        rd(op_offset, {26'h0, 2'h1, cls_nop}, 32'h3f);
        $display("two-word and flush done");
        exec(16'h26d6);
        compare_count(clear_count, 1);
        exec(16'h24d6);
        compare_count(clear_count, 1);
        assign_req <= 1'b0;
        exec(16'h26d6);
        compare_count(clear_count, 1);
        exec(16'h0004);
        exec(16'h00ff);
        compare_count(reset_count, 1);
        $display("side effects done");
        test_done;
    end
endmodule
